// ---- logic/itw_map.svh ----
// register map, field positions, reset values and timing figures of the interval timer
// assumes inclusion by the top module only
`ifndef ITW_MAP_SVH
`define ITW_MAP_SVH
`define ITW_ADDR_COUNT_CTRL 8'hEC
`define ITW_ADDR_WDT_CMP 8'hF0
`define ITW_ADDR_IRQ_STATUS 8'hF4
`define ITW_ADDR_IRQ_CLEAR 8'hF8
`define ITW_ADDR_IRQ_ENABLE 8'hFC
`define ITW_BIT_INT_CLEAR 3
`define ITW_BIT_WDT_CLEAR 7
`define ITW_IRQ_INTERVAL 0
`define ITW_IRQ_WATCHDOG 1
`define ITW_RST_CTRL 6'h00
`define ITW_RST_CMP 8'h00
`define ITW_RST_COUNT 8'h00
`define ITW_PRESC_BASE 11'h008
`define ITW_CLK_PERIOD_NS 20
`define ITW_WDT_RST_PULSE_NS 1000
`endif

// ---- logic/itw_pkg.sv ----
// types shared by the interval timer and watchdog
// assumes the map header beside it for all figures
package itw_pkg;
  typedef struct packed {
    logic rc_source_select;
    logic watchdog_reset_enable;
    logic interval_clear;
    logic [2:0] presc_sel;
  } itw_ctrl_t;
  typedef enum logic [1:0] {
    ITW_W_COLLECT = 2'h1,
    ITW_W_RESP = 2'h2
  } itw_wstate_t;
endpackage

// ---- logic/itw_top.sv ----
// interval timer with watchdog, AXI4-Lite register slave
// assumes inputs synchronous to core_clk; rc_tick is a one-cycle pulse per RC period
//
// Function
// - 8-bit interval counter runs freely; software cannot stop it.
// - interval counter advances on each prescaler pulse, divide 8 to 1024.
// - wrap from FF to 00 sets the interval interrupt flag.
// - control bits 2:0 pick divide 8,16,...,1024 for codes 000..111.
// - rc source bit makes the RC oscillator tick drive the counter.
// - writing interval clear zeroes counter; bit self-clears one cycle later.
// - one address: read gives count, write sets control bits.
// - stop with rc source halts all except RC, interval counter, watchdog.
// - 7-bit watchdog counter requests when equal to compare low seven bits.
// - request with reset enable drives reset low, else sets watchdog flag.
// - writing bit 7 of compare clears watchdog counter; self-clears next cycle.
// - watchdog advances once per interval, period is (compare+1) intervals.
// - reset enable is bit 4, zero after reset.
// - with system clock source watchdog pauses in stop and resumes.
// - with RC source watchdog keeps counting while oscillator stopped.
// - RC timeout follows RC period times interval length times (compare+1).
// - watchdog reset in sub clock mode turns the main oscillator on.
// - watchdog starts counting only after the interval counter is cleared.
`timescale 1ns/1ps
`include "itw_map.svh"
module itw_top #(
  parameter int unsigned CNT_W = 8,
  parameter int unsigned WDT_W = 7
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic stop_mode,
  input wire logic sub_clock_mode,
  input wire logic rc_tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wdt_reset_n,
  output logic main_osc_on,
  output logic periph_halt
);
  localparam int unsigned RST_CYC = `ITW_WDT_RST_PULSE_NS / `ITW_CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // register bus state
  itw_pkg::itw_wstate_t wstate_ff, nxt_wstate;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wlane_ff, nxt_wlane;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic do_write;
  logic wr_ctrl, wr_cmp, wr_clr, wr_en;

  always_comb begin
    nxt_wstate = wstate_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wlane = wlane_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    do_write = 1'b0;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wlane = s_axi_wstrb[0];
    end
    unique case (wstate_ff)
      itw_pkg::ITW_W_COLLECT: begin
        if (aw_have_ff && w_have_ff) begin
          do_write = 1'b1;
          nxt_aw_have = 1'b0;
          nxt_w_have = 1'b0;
          nxt_bvalid = 1'b1;
          nxt_bresp = (waddr_ff == `ITW_ADDR_COUNT_CTRL || waddr_ff == `ITW_ADDR_WDT_CMP ||
                       waddr_ff == `ITW_ADDR_IRQ_STATUS || waddr_ff == `ITW_ADDR_IRQ_CLEAR ||
                       waddr_ff == `ITW_ADDR_IRQ_ENABLE) ? RESP_OK : RESP_ERR;
          nxt_wstate = itw_pkg::ITW_W_RESP;
        end
      end
      itw_pkg::ITW_W_RESP: begin
        if (s_axi_bready) begin
          nxt_bvalid = 1'b0;
          nxt_wstate = itw_pkg::ITW_W_COLLECT;
        end
      end
    endcase
    nxt_awready = (nxt_wstate == itw_pkg::ITW_W_COLLECT) && !nxt_aw_have;
    nxt_wready = (nxt_wstate == itw_pkg::ITW_W_COLLECT) && !nxt_w_have;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wstate_ff <= itw_pkg::ITW_W_COLLECT;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else begin
      wstate_ff <= nxt_wstate;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wlane_ff <= nxt_wlane;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  assign wr_ctrl = do_write && wlane_ff && waddr_ff == `ITW_ADDR_COUNT_CTRL;
  assign wr_cmp = do_write && wlane_ff && waddr_ff == `ITW_ADDR_WDT_CMP;
  assign wr_clr = do_write && wlane_ff && waddr_ff == `ITW_ADDR_IRQ_CLEAR;
  assign wr_en = do_write && wlane_ff && waddr_ff == `ITW_ADDR_IRQ_ENABLE;

  // timer state
  itw_pkg::itw_ctrl_t ctrl_ff, nxt_ctrl;
  logic [9:0] presc_ff, nxt_presc;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [WDT_W-1:0] wdt_ff, nxt_wdt;
  logic [7:0] cmp_ff, nxt_cmp;
  logic armed_ff, nxt_armed;
  logic [1:0] status_ff, nxt_status, en_ff, nxt_en;
  logic [7:0] rst_cnt_ff, nxt_rst_cnt;
  logic irq_ff, wdt_rst_n_ff, osc_on_ff, halt_ff;
  logic [10:0] div_full;
  logic [9:0] div_mask;
  logic sys_tick, tick, ovf, match;
  logic [1:0] ev;

  always_comb begin
    div_full = `ITW_PRESC_BASE << ctrl_ff.presc_sel;
    div_mask = 10'(div_full - 11'h001);
    sys_tick = !stop_mode && ((presc_ff & div_mask) == div_mask);
    tick = ctrl_ff.rc_source_select ? rc_tick : sys_tick;
    ovf = tick && (cnt_ff == {CNT_W{1'b1}});
    match = ovf && armed_ff && (wdt_ff == cmp_ff[WDT_W-1:0]);
    ev = {match && !ctrl_ff.watchdog_reset_enable, ovf};
    nxt_presc = stop_mode ? presc_ff : 10'(presc_ff + 10'h001);
    nxt_cnt = tick ? CNT_W'(cnt_ff + 1'b1) : cnt_ff;
    nxt_wdt = wdt_ff;
    if (match) begin
      nxt_wdt = '0;
    end else if (ovf && armed_ff) begin
      nxt_wdt = WDT_W'(wdt_ff + 1'b1);
    end
    nxt_ctrl = ctrl_ff;
    nxt_ctrl.interval_clear = 1'b0;
    nxt_armed = armed_ff;
    if (wr_ctrl) begin
      nxt_ctrl = itw_pkg::itw_ctrl_t'(wdata_ff[5:0]);
      if (wdata_ff[`ITW_BIT_INT_CLEAR]) begin
        nxt_cnt = '0;
        nxt_presc = 10'h000;
        nxt_armed = 1'b1;
      end
    end
    nxt_cmp = cmp_ff;
    nxt_cmp[`ITW_BIT_WDT_CLEAR] = 1'b0;
    if (wr_cmp) begin
      nxt_cmp = wdata_ff;
      if (wdata_ff[`ITW_BIT_WDT_CLEAR]) begin
        nxt_wdt = '0;
      end
    end
    nxt_en = wr_en ? wdata_ff[1:0] : en_ff;
    // a new event wins over a clear in the same cycle
    nxt_status = (status_ff & ~(wr_clr ? wdata_ff[1:0] : 2'h0)) | ev;
    nxt_rst_cnt = rst_cnt_ff;
    if (match && ctrl_ff.watchdog_reset_enable) begin
      nxt_rst_cnt = 8'(RST_CYC);
    end else if (rst_cnt_ff != 8'h00) begin
      nxt_rst_cnt = 8'(rst_cnt_ff - 8'h01);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= itw_pkg::itw_ctrl_t'(`ITW_RST_CTRL);
      presc_ff <= 10'h000;
      cnt_ff <= '0;
      wdt_ff <= '0;
      cmp_ff <= `ITW_RST_CMP;
      armed_ff <= 1'b0;
      status_ff <= 2'h0;
      en_ff <= 2'h0;
      rst_cnt_ff <= 8'h00;
      irq_ff <= 1'b0;
      wdt_rst_n_ff <= 1'b1;
      osc_on_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      presc_ff <= nxt_presc;
      cnt_ff <= nxt_cnt;
      wdt_ff <= nxt_wdt;
      cmp_ff <= nxt_cmp;
      armed_ff <= nxt_armed;
      status_ff <= nxt_status;
      en_ff <= nxt_en;
      rst_cnt_ff <= nxt_rst_cnt;
      irq_ff <= |(status_ff & en_ff);
      wdt_rst_n_ff <= (nxt_rst_cnt == 8'h00);
      osc_on_ff <= match && ctrl_ff.watchdog_reset_enable && sub_clock_mode;
      halt_ff <= stop_mode && ctrl_ff.rc_source_select;
    end
  end

  // read channel
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OK;
      unique case (s_axi_araddr)
        `ITW_ADDR_COUNT_CTRL: nxt_rdata = {24'h000000, cnt_ff};
        `ITW_ADDR_WDT_CMP: nxt_rdata = {24'h000000, cmp_ff};
        `ITW_ADDR_IRQ_STATUS: nxt_rdata = {30'h00000000, status_ff};
        `ITW_ADDR_IRQ_ENABLE: nxt_rdata = {30'h00000000, en_ff};
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = (s_axi_araddr == `ITW_ADDR_IRQ_CLEAR) ? RESP_OK : RESP_ERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
      arready_ff <= 1'b0;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      arready_ff <= nxt_arready;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq = irq_ff;
  assign wdt_reset_n = wdt_rst_n_ff;
  assign main_osc_on = osc_on_ff;
  assign periph_halt = halt_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  cnt_free_a: assert property (tick && !wr_ctrl |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("interval counter did not advance");
  cnt_hold_a: assert property (!tick && !wr_ctrl |=> $stable(cnt_ff))
    else $error("interval counter moved without a tick");
  div_sel_a: assert property (!ctrl_ff.rc_source_select && sys_tick |->
    presc_ff[2:0] == 3'h7 && (ctrl_ff.presc_sel != 3'h7 || presc_ff == 10'h3FF))
    else $error("prescaler tick at wrong count");
  ovf_flag_a: assert property (ovf && !wr_ctrl |=> status_ff[0] && cnt_ff == 8'h00)
    else $error("wrap did not set interval flag");
  clr_bit_a: assert property (wr_ctrl && wdata_ff[3] |=> ctrl_ff.interval_clear && cnt_ff == 8'h00
    ##1 !ctrl_ff.interval_clear)
    else $error("interval clear misbehaved");
  wdt_clr_a: assert property (wr_cmp && wdata_ff[7] |=> wdt_ff == 7'h00 ##1 !cmp_ff[7])
    else $error("watchdog clear misbehaved");
  wdt_rst_a: assert property (match && ctrl_ff.watchdog_reset_enable |=> !wdt_reset_n)
    else $error("watchdog reset not driven");
  wdt_int_a: assert property (match && !ctrl_ff.watchdog_reset_enable |=> status_ff[1])
    else $error("watchdog flag not set");
  wdt_arm_a: assert property (!armed_ff |-> wdt_ff == 7'h00)
    else $error("watchdog counted before arming");
  stop_hold_a: assert property (stop_mode && !ctrl_ff.rc_source_select && !wr_cmp
    |=> $stable(wdt_ff))
    else $error("watchdog moved in stop");
  osc_on_a: assert property (match && ctrl_ff.watchdog_reset_enable && sub_clock_mode
    |=> main_osc_on)
    else $error("main oscillator not restarted");
  halt_a: assert property (stop_mode && ctrl_ff.rc_source_select |=> periph_halt)
    else $error("halt not raised");

  ovf_c: cover property (ovf);
  wdt_int_c: cover property (match && !ctrl_ff.watchdog_reset_enable);
  wdt_rst_c: cover property (match && ctrl_ff.watchdog_reset_enable);
  rc_stop_c: cover property (stop_mode && ctrl_ff.rc_source_select && rc_tick);
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the interval timer and watchdog over its AXI4-Lite port
// assumes the design's own assertions run inside it; bench drives every input directly
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic stop_mode = 1'b0;
  logic sub_clock_mode = 1'b0;
  logic rc_tick = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, wdt_reset_n, main_osc_on, periph_halt;
  int err_total = 0;
  int check_count = 0;
  int n, c, lowc, osc;

  always #10 core_clk = ~core_clk;

  itw_top uut (
    .core_clk(core_clk), .rstn(rstn), .stop_mode(stop_mode),
    .sub_clock_mode(sub_clock_mode), .rc_tick(rc_tick),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
    .wdt_reset_n(wdt_reset_n), .main_osc_on(main_osc_on), .periph_halt(periph_halt)
  );

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write one word; response code compared, response must follow both takes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic got;
    logic aw_ok;
    logic w_ok;
    got = 1'b0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge core_clk);
      if (s_axi_bvalid === 1'b1) begin
        got = 1'b1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        chk({30'h0, aw_ok, w_ok}, 32'h3);
      end
      if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  // read one word; data and response compared, data must follow the take
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic got;
    logic ar_ok;
    got = 1'b0;
    ar_ok = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge core_clk);
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        chk({31'h0, ar_ok}, 32'h1);
      end
      if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    cyc(60000);
    err_total++;
    end_sim;
  end

  initial begin
    cyc(8);
    rstn <= 1'b1;
    cyc(4);
    rd(8'hEC, 32'h0, 2'h0);
    rd(8'hF0, 32'h0, 2'h0);
    rd(8'hF4, 32'h0, 2'h0);
    rd(8'hFC, 32'h0, 2'h0);
    rd(8'h10, 32'h0, 2'h2);
    rd(8'hF8, 32'h0, 2'h0);
    wr(8'h10, 32'h0, 2'h2);
    // lane 0 strobe low: write ignored
    s_axi_wstrb <= 4'h0;
    wr(8'hF0, 32'h7F, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'hF0, 32'h0, 2'h0);
    chk({31'h0, wdt_reset_n}, 32'h1);
    // every divide code: three counts after clear
    for (c = 0; c < 8; c++) begin
      wr(8'hEC, 32'h08 | c, 2'h0);
      cyc(3 * (8 << c) + (8 << c) / 4);
      rd(8'hEC, 32'h3, 2'h0);
    end
    // wrap with compare zero: both flags, masked then enabled
    wr(8'hEC, 32'h08, 2'h0);
    cyc(2100);
    rd(8'hF4, 32'h3, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'hFC, 32'h1, 2'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(8'hF8, 32'h1, 2'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd(8'hF4, 32'h2, 2'h0);
    wr(8'hF8, 32'h3, 2'h0);
    // compare one: two intervals, restarted by counter clear
    wr(8'hF0, 32'h01, 2'h0);
    wr(8'hEC, 32'h08, 2'h0);
    wr(8'hF0, 32'h81, 2'h0);
    cyc(3000);
    // one wrap seen: interval flag only
    rd(8'hF4, 32'h1, 2'h0);
    wr(8'hF0, 32'h81, 2'h0);
    cyc(2000);
    rd(8'hF4, 32'h1, 2'h0);
    wr(8'hF8, 32'h3, 2'h0);
    cyc(2048);
    // second wrap after the clear: match plus interval flag
    rd(8'hF4, 32'h3, 2'h0);
    // system clock stop freezes the count
    wr(8'hEC, 32'h08, 2'h0);
    stop_mode <= 1'b1;
    cyc(200);
    rd(8'hEC, 32'h0, 2'h0);
    // rc source keeps counting in stop
    wr(8'hEC, 32'h28, 2'h0);
    cyc(3);
    chk({31'h0, periph_halt}, 32'h1);
    repeat (5) begin
      rc_tick <= 1'b1;
      @(posedge core_clk);
      rc_tick <= 1'b0;
      cyc(3);
    end
    rd(8'hEC, 32'h5, 2'h0);
    stop_mode <= 1'b0;
    cyc(3);
    chk({31'h0, periph_halt}, 32'h0);
    // reset mode from sub clock
    sub_clock_mode <= 1'b1;
    wr(8'hF0, 32'h81, 2'h0);
    wr(8'hEC, 32'h18, 2'h0);
    lowc = 0;
    osc = 0;
    for (n = 0; n < 6000; n++) begin
      @(posedge core_clk);
      if (wdt_reset_n === 1'b0) lowc++;
      if (main_osc_on === 1'b1) osc++;
    end
    chk(lowc, 50);
    chk(osc, 1);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(4);
    rd(8'hEC, 32'h0, 2'h0);
    rd(8'hF0, 32'h0, 2'h0);
    end_sim;
  end
endmodule
